// [bench/scp_peer.sv]
// remote start-stop peer that drives the receive line of the port
`timescale 1ns/1ps
`default_nettype none
module scp_peer (
   input wire logic hclk,
   output logic line
);
   int bit_clks = 4;
   initial line = 1'b1;
   // one frame with the stop level chosen by the caller, then idle high
   task automatic send(input logic [8:0] d, input int nb, input logic stop);
      line <= 1'b0;
      repeat (bit_clks) @(posedge hclk);
      for (int i = 0; i < nb; i++)
      begin
         line <= d[i];
         repeat (bit_clks) @(posedge hclk);
      end
      line <= stop;
      repeat (bit_clks) @(posedge hclk);
      line <= 1'b1;
      repeat (2 * bit_clks) @(posedge hclk);
   endtask
endmodule
`default_nettype wire

// [bench/scp_serial_port_bench.sv]
// self-checking bench for the serial port control registers
`timescale 1ns/1ps
`default_nettype none
module scp_serial_port_bench;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_line;
   logic [31:0] haddr, hwdata, hrdata, rv;
   logic [1:0] htrans;
   scp_pkg::scp_pin_out_t pin_out;
   scp_pkg::scp_pin_in_t pin_in;
   int n_fail = 0;
   int n_tests = 0;
   int cyc = 0;
   assign pin_in = '{rxdt: rx_line, txck: 1'b1};
   scp_serial_port i_scp_serial_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pin_in(pin_in), .pin_out(pin_out));
   scp_peer i_scp_peer (.hclk(hclk), .line(rx_line));
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // waits for hready high at a rising edge, bounded
   task automatic rdy;
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 64);
      if (k >= 64) chk("hready_wait", 32'h1, 32'h0);
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rdy;
      rv = hrdata;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      xfer(1'b0, a, 32'h0);
      chk(nm, e, rv);
   endtask
   // checks one transmitted frame at mid-bit, four clocks a bit
   task automatic txf(input logic [13:0] b, input int n);
      int k;
      k = 0;
      while (pin_out.txck !== 1'b0 && k < 200)
      begin
         @(posedge hclk);
         k++;
      end
      repeat (2) @(posedge hclk);
      for (int i = 0; i < n; i++)
      begin
         chk("tx_line", {31'h0, b[i]}, {31'h0, pin_out.txck});
         repeat (4) @(posedge hclk);
      end
   endtask
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         results;
      end
   end
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      chk("txck_oe_n", 32'h1, {31'h0, pin_out.txck_oe_n});
      chk("txck_idle", 32'h1, {31'h0, pin_out.txck});
      rd(8'h00, 32'h02, "txsc_reset");
      rd(8'h04, 32'h00, "rxsc_reset");
      rd(8'h08, 32'h40, "baud_reset");
      chk("hresp", 32'h0, {31'h0, hresp});
      xfer(1'b1, 8'h08, 32'h2C);
      rd(8'h08, 32'h48, "baud_rw");
      xfer(1'b1, 8'h14, 32'h0);
      xfer(1'b1, 8'h04, 32'h80);
      @(negedge hclk);
      chk("txck_oe_n", 32'h0, {31'h0, pin_out.txck_oe_n});
      xfer(1'b1, 8'h00, 32'h24);
      xfer(1'b1, 8'h0C, 32'hA5);
      txf({4'h0, 1'b1, 8'hA5, 1'b0}, 10);
      repeat (8) @(posedge hclk);
      rd(8'h00, 32'h26, "tx_empty");
      xfer(1'b1, 8'h00, 32'h65);
      xfer(1'b1, 8'h0C, 32'h3C);
      txf({3'h0, 1'b1, 1'b1, 8'h3C, 1'b0}, 11);
      xfer(1'b1, 8'h00, 32'h2C);
      xfer(1'b1, 8'h0C, 32'h55);
      txf(14'h2000, 14);
      repeat (8) @(posedge hclk);
      rd(8'h00, 32'h26, "break_done");
      xfer(1'b1, 8'h08, 32'h18);
      @(negedge hclk);
      chk("txck_inv", 32'h0, {31'h0, pin_out.txck});
      xfer(1'b1, 8'h08, 32'h08);
      xfer(1'b1, 8'h04, 32'h90);
      i_scp_peer.send(9'h05A, 8, 1'b1);
      rd(8'h18, 32'h03, "event");
      rd(8'h10, 32'h5A, "rx_data");
      i_scp_peer.send(9'h070, 8, 1'b0);
      rd(8'h04, 32'h94, "framing_error");
      rd(8'h10, 32'h70, "rx_bad");
      i_scp_peer.send(9'h011, 8, 1'b1);
      i_scp_peer.send(9'h022, 8, 1'b1);
      i_scp_peer.send(9'h033, 8, 1'b1);
      rd(8'h04, 32'h92, "ovr");
      rd(8'h10, 32'h11, "rx_first");
      rd(8'h10, 32'h22, "rx_second");
      xfer(1'b1, 8'h04, 32'h80);
      rd(8'h04, 32'h80, "ovr_clr");
      xfer(1'b1, 8'h04, 32'hD8);
      i_scp_peer.send(9'h033, 9, 1'b1);
      rd(8'h18, 32'h02, "addr_drop");
      i_scp_peer.send(9'h1A7, 9, 1'b1);
      rd(8'h04, 32'hD9, "rx_ninth");
      rd(8'h10, 32'hA7, "rx_addr");
      rd(8'h18, 32'h02, "flag_clear");
      xfer(1'b1, 8'h08, 32'h0A);
      i_scp_peer.send(9'h0FF, 8, 1'b1);
      rd(8'h08, 32'h48, "wake_clear");
      rd(8'h18, 32'h03, "wake_flag");
      xfer(1'b1, 8'h04, 32'h00);
      @(negedge hclk);
      chk("txck_oe_n", 32'h1, {31'h0, pin_out.txck_oe_n});
      results;
   end
endmodule
`default_nettype wire

// [src/scp_params.svh]
// register map, reset values and rate constants of the serial port
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
`define SCP_OFF_TXSC 8'h00
`define SCP_OFF_RXSC 8'h04
`define SCP_OFF_BAUD 8'h08
`define SCP_OFF_TXDATA 8'h0C
`define SCP_OFF_RXDATA 8'h10
`define SCP_OFF_DIV 8'h14
`define SCP_OFF_EVENT 8'h18
`define SCP_TSE_RESET 1'b1
`define SCP_RIDL_RESET 1'b1
`define SCP_DIV_RESET 16'h0000
`define SCP_SCALE_FAST 7'h04
`define SCP_SCALE_MID 7'h10
`define SCP_SCALE_SLOW 7'h40
`define SCP_SHIFT_FAST 4'h2
`define SCP_SHIFT_MID 4'h4
`define SCP_SHIFT_SLOW 4'h6
`define SCP_BREAK_LAST 4'hB
`define SCP_NINE_LAST 4'h8
`define SCP_EIGHT_LAST 4'h7
`endif

// [src/scp_pkg.sv]
// types shared by the serial port control logic
package scp_pkg;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_START = 2'b01,
      TX_DATA = 2'b10,
      TX_STOP = 2'b11
   } scp_tx_state_t;
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } scp_rx_state_t;
   typedef struct packed {
      logic rxdt;
      logic txck;
   } scp_pin_in_t;
   typedef struct packed {
      logic txck;
      logic txck_oe_n;
      logic dt;
      logic dt_oe_n;
   } scp_pin_out_t;
   typedef struct packed {
      logic [15:0] cnt;
      logic tick;
   } scp_div_state_t;
   typedef struct packed {
      logic clk_src, tx9, transmit_enable, mode, brk, hs, tx_ninth_bit;
      logic pen, rx9, sre, cre, ade, ovr;
      logic ab_ovf, pol, w16, wake_on_edge_enable, abe;
      logic [15:0] div;
      scp_tx_state_t tx_state;
      logic [8:0] tx_buf;
      logic tx_buf_full;
      logic [11:0] tx_shift_register;
      logic tx_brk;
      logic tse;
      logic [3:0] tx_cnt;
      logic [5:0] tx_phase;
      scp_rx_state_t rx_state;
      logic [8:0] rx_shift;
      logic [3:0] rx_cnt;
      logic [5:0] rx_phase;
      logic ridl;
      logic [1:0][9:0] fifo;
      logic fifo_head;
      logic [1:0] fifo_cnt;
      logic wake_flag;
      logic ab_meas;
      logic [15:0] ab_cnt;
      logic ck_gen;
      logic [5:0] ck_phase;
      logic rx_s1, rx_s2, rx_d, ck_s1, ck_s2, ck_d;
      logic ap_valid, ap_write, rd_wait;
      logic [7:0] ap_addr;
      logic [31:0] hrdata;
   } scp_state_t;
endpackage

// [src/scp_rate_div.sv]
// rate divider: one-cycle tick every limit+1 clocks, 8- or 16-bit limit
`timescale 1ns/1ps
`default_nettype none
module scp_rate_div (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic run,
   input wire logic wide,
   input wire logic [15:0] limit_value,
   output logic tick
);
   scp_pkg::scp_div_state_t s_reg;
   scp_pkg::scp_div_state_t s_next;
   logic [15:0] limit;

   always_comb
   begin
      s_next = s_reg;
      limit = wide ? limit_value : {8'h00, limit_value[7:0]};
      if (!run)
      begin
         s_next.cnt = 16'h0000;
         s_next.tick = 1'b0;
      end
      else if (s_reg.cnt >= limit)
      begin
         s_next.cnt = 16'h0000;
         s_next.tick = 1'b1;
      end
      else
      begin
         s_next.cnt = s_reg.cnt + 16'h0001;
         s_next.tick = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign tick = s_reg.tick;
endmodule
`default_nettype wire

// [src/scp_serial_port.sv]
// serial port control, status and character engines behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "scp_params.svh"
module scp_serial_port (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire scp_pkg::scp_pin_in_t pin_in,
   output scp_pkg::scp_pin_out_t pin_out
);
   scp_pkg::scp_state_t s;
   scp_pkg::scp_state_t n;
   logic tick, line, rx, rx_fall, rx_rise, ck_edge, sbusy, mtog, sample_e;
   logic tx_bit_end, rx_bit_end, go_async, go_sync, push, pop, wake_set, ab_set;
   logic accept, rd_stall, step;
   logic [6:0] scale;
   logic [5:0] half;
   logic [3:0] tx_last, rx_last;
   logic [8:0] sh_new;
   logic [9:0] push_word;
   logic [1:0] cnt_left;
   logic [15:0] ab_q;

   function automatic logic [6:0] scale_of(input logic sync, input logic hs, input logic w16);
      if (sync || (hs && w16))
         scale_of = `SCP_SCALE_FAST;
      else if (hs || w16)
         scale_of = `SCP_SCALE_MID;
      else
         scale_of = `SCP_SCALE_SLOW;
   endfunction

   function automatic logic [8:0] rx_word(input logic nine, input logic [8:0] sh);
      rx_word = nine ? sh : {1'b0, sh[8:1]};
   endfunction

   function automatic logic [31:0] read_word(input logic [7:0] a, input scp_pkg::scp_state_t st);
      logic [9:0] h;
      h = st.fifo[st.fifo_head];
      case (a)
         `SCP_OFF_TXSC: read_word = {24'h000000, st.clk_src, st.tx9, st.transmit_enable, st.mode, st.brk,
                                     st.hs, st.tse, st.tx_ninth_bit};
         `SCP_OFF_RXSC: read_word = {24'h000000, st.pen, st.rx9, st.sre, st.cre, st.ade,
                                     h[9], st.ovr, h[8]};
         `SCP_OFF_BAUD: read_word = {24'h000000, st.ab_ovf, st.ridl, 1'b0, st.pol, st.w16,
                                     1'b0, st.wake_on_edge_enable, st.abe};
         `SCP_OFF_RXDATA: read_word = {24'h000000, h[7:0]};
         `SCP_OFF_DIV: read_word = {16'h0000, st.div};
         `SCP_OFF_EVENT: read_word = {30'h00000000, st.transmit_enable & ~st.tx_buf_full,
                                      (st.fifo_cnt != 2'h0) | st.wake_flag};
         default: read_word = 32'h00000000;
      endcase
   endfunction

   scp_rate_div u_div (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(s.pen),
      .wide(s.w16),
      .limit_value(s.div),
      .tick(tick)
   );

   always_comb
   begin
      n = s;
      // pin synchronisers; the second stage is looked at, and the third stage for edges
      n.rx_s1 = pin_in.rxdt;
      n.rx_s2 = s.rx_s1;
      n.rx_d = s.rx_s2;
      n.ck_s1 = pin_in.txck;
      n.ck_s2 = s.ck_s1;
      n.ck_d = s.ck_s2;
      rx = s.rx_s2;
      rx_fall = s.rx_d & ~s.rx_s2;
      rx_rise = ~s.rx_d & s.rx_s2;
      ck_edge = s.ck_d ^ s.ck_s2;
      scale = scale_of(s.mode, s.hs, s.w16);
      half = scale[6:1];
      tx_bit_end = tick && (s.tx_phase == 6'(scale - 7'h01));
      rx_bit_end = tick && (s.rx_phase == 6'(scale - 7'h01));
      tx_last = s.tx_brk ? `SCP_BREAK_LAST : (s.tx9 ? `SCP_NINE_LAST : `SCP_EIGHT_LAST);
      rx_last = s.rx9 ? `SCP_NINE_LAST : `SCP_EIGHT_LAST;
      // clocked mode: master makes the clock, slave follows the pin
      sbusy = s.pen && s.mode && (s.tx_state == scp_pkg::TX_DATA || s.rx_state == scp_pkg::RX_DATA);
      mtog = sbusy && s.clk_src && tick && (s.ck_phase == half - 6'h01);
      if (sbusy && s.clk_src)
      begin
         if (tick)
            n.ck_phase = mtog ? 6'h00 : s.ck_phase + 6'h01;
         if (mtog)
            n.ck_gen = ~s.ck_gen;
      end
      else
      begin
         n.ck_phase = 6'h00;
         n.ck_gen = s.pol;
      end
      // sampling edge is rising with polarity set, falling otherwise
      sample_e = s.clk_src ? (mtog && (s.ck_gen != s.pol)) : (ck_edge && (s.ck_s2 == s.pol));
      // transmitter
      line = 1'b1;
      step = 1'b0;
      if (tick)
         n.tx_phase = tx_bit_end ? 6'h00 : s.tx_phase + 6'h01;
      unique case (s.tx_state)
         scp_pkg::TX_IDLE:
         begin
            if (s.pen && s.transmit_enable && s.tx_buf_full && !(s.mode && (s.sre || s.cre)))
            begin
               n.tx_buf_full = 1'b0;
               n.tse = 1'b0;
               n.tx_cnt = 4'h0;
               n.tx_phase = 6'h00;
               if (!s.mode && s.brk)
               begin
                  n.tx_shift_register = 12'h000;
                  n.tx_brk = 1'b1;
                  n.tx_state = scp_pkg::TX_START;
               end
               else
               begin
                  n.tx_shift_register = {3'h0, s.tx9 ? s.tx_buf : {1'b0, s.tx_buf[7:0]}};
                  n.tx_brk = 1'b0;
                  n.tx_state = s.mode ? scp_pkg::TX_DATA : scp_pkg::TX_START;
               end
            end
         end
         scp_pkg::TX_START:
         begin
            line = 1'b0;
            if (tx_bit_end)
               n.tx_state = scp_pkg::TX_DATA;
         end
         scp_pkg::TX_DATA:
         begin
            line = s.tx_shift_register[0];
            step = s.mode ? sample_e : tx_bit_end;
            if (step)
            begin
               n.tx_shift_register = {1'b0, s.tx_shift_register[11:1]};
               n.tx_cnt = s.tx_cnt + 4'h1;
               if (s.tx_cnt == tx_last)
               begin
                  n.tx_state = s.mode ? scp_pkg::TX_IDLE : scp_pkg::TX_STOP;
                  n.tse = s.mode;
               end
            end
         end
         scp_pkg::TX_STOP:
         begin
            line = 1'b1;
            if (tx_bit_end)
            begin
               n.tx_state = scp_pkg::TX_IDLE;
               n.tse = 1'b1;
               if (s.tx_brk)
                  n.brk = 1'b0;
            end
         end
      endcase
      // receiver
      go_async = s.pen && !s.mode && s.cre && !s.wake_on_edge_enable && !s.abe && !s.ovr;
      go_sync = s.pen && s.mode && (s.cre || (s.sre && s.clk_src)) && !s.ovr;
      push = 1'b0;
      push_word = 10'h000;
      sh_new = {rx, s.rx_shift[8:1]};
      if (tick)
         n.rx_phase = rx_bit_end ? 6'h00 : s.rx_phase + 6'h01;
      unique case (s.rx_state)
         scp_pkg::RX_IDLE:
         begin
            n.ridl = 1'b1;
            if (go_sync)
            begin
               n.rx_state = scp_pkg::RX_DATA;
               n.rx_cnt = 4'h0;
            end
            else if (go_async && rx_fall)
            begin
               n.rx_state = scp_pkg::RX_START;
               n.rx_phase = 6'h00;
               n.ridl = 1'b0;
            end
         end
         scp_pkg::RX_START:
         begin
            if (!go_async)
               n.rx_state = scp_pkg::RX_IDLE;
            else if (tick && s.rx_phase == half - 6'h01)
            begin
               n.rx_phase = 6'h00;
               n.rx_cnt = 4'h0;
               n.rx_state = rx ? scp_pkg::RX_IDLE : scp_pkg::RX_DATA;
            end
         end
         scp_pkg::RX_DATA:
         begin
            step = s.mode ? sample_e : rx_bit_end;
            if (!(go_async || go_sync))
               n.rx_state = scp_pkg::RX_IDLE;
            else if (step)
            begin
               n.rx_shift = sh_new;
               n.rx_cnt = s.rx_cnt + 4'h1;
               if (s.rx_cnt == rx_last)
               begin
                  if (s.mode)
                  begin
                     push = 1'b1;
                     push_word = {1'b0, rx_word(s.rx9, sh_new)};
                     n.rx_cnt = 4'h0;
                     if (!s.cre)
                     begin
                        n.sre = 1'b0;
                        n.rx_state = scp_pkg::RX_IDLE;
                     end
                  end
                  else
                     n.rx_state = scp_pkg::RX_STOP;
               end
            end
         end
         scp_pkg::RX_STOP:
         begin
            if (!go_async)
               n.rx_state = scp_pkg::RX_IDLE;
            else if (rx_bit_end)
            begin
               n.rx_state = scp_pkg::RX_IDLE;
               push = !(s.rx9 && s.ade) || s.rx_shift[8];
               push_word = {~rx, rx_word(s.rx9, s.rx_shift)};
            end
         end
      endcase
      // wake-up on falling edge and automatic rate measurement
      wake_set = 1'b0;
      ab_set = 1'b0;
      if (s.pen && !s.mode && s.wake_on_edge_enable && rx_fall)
      begin
         n.wake_on_edge_enable = 1'b0;
         wake_set = 1'b1;
      end
      ab_q = (scale == `SCP_SCALE_FAST) ? (s.ab_cnt >> `SCP_SHIFT_FAST) :
             (scale == `SCP_SCALE_MID) ? (s.ab_cnt >> `SCP_SHIFT_MID) : (s.ab_cnt >> `SCP_SHIFT_SLOW);
      if (s.pen && !s.mode && s.abe)
      begin
         if (!s.ab_meas)
         begin
            if (rx_fall)
            begin
               n.ab_meas = 1'b1;
               n.ab_cnt = 16'h0000;
            end
         end
         else if (rx_rise)
         begin
            n.div = (ab_q == 16'h0000) ? 16'h0000 : ab_q - 16'h0001;
            n.abe = 1'b0;
            n.ab_meas = 1'b0;
         end
         else if (&s.ab_cnt)
         begin
            ab_set = 1'b1;
            n.abe = 1'b0;
            n.ab_meas = 1'b0;
         end
         else
            n.ab_cnt = s.ab_cnt + 16'h0001;
      end
      else
         n.ab_meas = 1'b0;
      // disabled port: engines and transmit buffer held in reset, receive buffer count and control bits kept
      if (!s.pen)
      begin
         n.tx_state = scp_pkg::TX_IDLE;
         n.tx_buf_full = 1'b0;
         n.tse = 1'b1;
         n.rx_state = scp_pkg::RX_IDLE;
         n.ridl = 1'b1;
         n.fifo_cnt = 2'h0;
         n.ovr = 1'b0;
         n.wake_flag = 1'b0;
      end
      // bus slave: writes land in the data phase, reads take one wait state
      accept = hsel && htrans[1] && hready;
      rd_stall = s.ap_valid && !s.ap_write && !s.rd_wait;
      n.ap_valid = accept;
      n.rd_wait = rd_stall;
      if (accept)
      begin
         n.ap_write = hwrite;
         n.ap_addr = haddr[7:0];
      end
      pop = 1'b0;
      if (rd_stall)
      begin
         n.hrdata = read_word(s.ap_addr, s);
         if (s.ap_addr == `SCP_OFF_RXDATA)
         begin
            pop = (s.fifo_cnt != 2'h0);
            n.wake_flag = 1'b0;
         end
      end
      if (s.ap_valid && s.ap_write)
      begin
         case (s.ap_addr)
            `SCP_OFF_TXSC:
            begin
               {n.clk_src, n.tx9, n.transmit_enable, n.mode, n.brk, n.hs} = hwdata[7:2];
               n.tx_ninth_bit = hwdata[0];
            end
            `SCP_OFF_RXSC:
            begin
               {n.pen, n.rx9, n.sre, n.cre, n.ade} = hwdata[7:3];
               if (!hwdata[4])
                  n.ovr = 1'b0;
            end
            `SCP_OFF_BAUD:
            begin
               {n.pol, n.w16} = hwdata[4:3];
               {n.wake_on_edge_enable, n.abe} = hwdata[1:0];
               if (hwdata[0])
                  n.ab_ovf = 1'b0;
            end
            `SCP_OFF_TXDATA:
            begin
               if (!s.tx_buf_full && s.pen)
               begin
                  n.tx_buf = {s.tx_ninth_bit, hwdata[7:0]};
                  n.tx_buf_full = 1'b1;
               end
            end
            `SCP_OFF_DIV: n.div = hwdata[15:0];
            default: n.div = n.div;
         endcase
      end
      // receive buffer of two characters; hardware sets win over clears
      cnt_left = s.fifo_cnt - {1'b0, pop};
      if (pop)
      begin
         n.fifo_head = ~s.fifo_head;
      end
      n.fifo_cnt = cnt_left;
      if (push)
      begin
         if (cnt_left == 2'h2)
            n.ovr = 1'b1;
         else
         begin
            n.fifo[n.fifo_head ^ (cnt_left == 2'h1)] = push_word;
            n.fifo_cnt = cnt_left + 2'h1;
         end
      end
      if (wake_set)
         n.wake_flag = 1'b1;
      if (ab_set)
         n.ab_ovf = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= '0;
         s.tse <= `SCP_TSE_RESET;
         s.ridl <= `SCP_RIDL_RESET;
         s.div <= `SCP_DIV_RESET;
         s.rx_s1 <= 1'b1;
         s.rx_s2 <= 1'b1;
         s.rx_d <= 1'b1;
      end
      else
         s <= n;
   end

   assign hrdata = s.hrdata;
   assign hreadyout = !(s.ap_valid && !s.ap_write && !s.rd_wait);
   assign hresp = 1'b0;
   assign pin_out.txck = s.mode ? s.ck_gen : (line ^ s.pol);
   assign pin_out.txck_oe_n = !s.pen || (s.mode && !s.clk_src);
   assign pin_out.dt = s.tx_shift_register[0];
   assign pin_out.dt_oe_n = !(s.pen && s.mode && s.tx_state == scp_pkg::TX_DATA
                              && !(s.sre || s.cre));

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   tse_busy_a: assert property (s.tx_state != scp_pkg::TX_IDLE |-> !s.tse)
      else $error("shift empty set while transmitting");
   break_low_a: assert property (s.tx_brk && s.tx_state == scp_pkg::TX_DATA && !s.mode
                                 |-> pin_out.txck == s.pol)
      else $error("break character not at space level");
   port_off_a: assert property (!s.pen |-> pin_out.txck_oe_n && pin_out.dt_oe_n)
      else $error("pins driven while port disabled");
   rx_idle_a: assert property (s.rx_state == scp_pkg::RX_IDLE |=> s.ridl || !s.pen
                               || s.rx_state != scp_pkg::RX_IDLE)
      else $error("receive idle low while receiver idle");
   ovr_clear_a: assert property ($fell(s.cre) |-> !s.ovr)
      else $error("overrun kept after continuous receive cleared");
   wake_edge_a: assert property (s.pen && !s.mode && s.wake_on_edge_enable && rx_fall |=> !s.wake_on_edge_enable && s.wake_flag)
      else $error("wake edge did not set flag and clear enable");
   rx_over_tx_a: assert property (s.mode && (s.sre || s.cre) |-> pin_out.dt_oe_n)
      else $error("data pin driven while receive enabled");
   idle_level_a: assert property (s.pen && !s.mode && s.tx_state == scp_pkg::TX_IDLE
                                  |-> pin_out.txck == ~s.pol)
      else $error("transmit idle level wrong for polarity");
   slave_clk_a: assert property (s.mode && !s.clk_src |-> pin_out.txck_oe_n)
      else $error("slave drives the clock pin");
endmodule
`default_nettype wire
